// [pkg/nv_access_pkg.sv]
// Constants, types and decode shared by the nonvolatile byte access block.
// Assumes a special-function register port with bank select, as seen by the core.
package nv_access_pkg;

  localparam logic [7:0] ADDR_REG_OFS  = 8'h1e;
  localparam logic [7:0] DATA_REG_OFS  = 8'h1f;
  localparam logic [7:0] CTRL_REG_OFS  = 8'h40;
  localparam logic [1:0] CTRL_BANK     = 2'h1;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam int         WR_PERMIT_BIT = 3;
  localparam int         WR_TRIG_BIT   = 2;
  localparam int         RD_PERMIT_BIT = 1;
  localparam int         RD_TRIG_BIT   = 0;
  localparam int         ADDR_W        = 6;
  localparam int         NV_DEPTH      = 128;
  localparam int         RD_CYCLES     = 4;
  localparam int         WR_TICKS      = 4;

  typedef struct packed {
    logic write_permit;
    logic write_trigger;
    logic read_permit;
    logic read_trigger;
  } nv_ctrl_s;

  localparam nv_ctrl_s CTRL_RESET = '{default: 1'b0};

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_ADDR = 2'h1,
    SEL_DATA = 2'h2,
    SEL_CTRL = 2'h3
  } reg_sel_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h2
  } nv_state_e;

  // Address and data live in the common area; control only in its bank
  function automatic reg_sel_e reg_sel(input logic [1:0] bank, input logic [7:0] ofs);
    reg_sel_e s;
    s = SEL_NONE;
    if (ofs == ADDR_REG_OFS)
      s = SEL_ADDR;
    else if (ofs == DATA_REG_OFS)
      s = SEL_DATA;
    else if (ofs == CTRL_REG_OFS && bank == CTRL_BANK)
      s = SEL_CTRL;
    return s;
  endfunction

endpackage

// [design/eeprom_byte_access_ctrl.sv]
// Byte access engine for the on-chip nonvolatile data store.
// Assumes the core's register port (bank, offset, write strobe) and a free-running
// asynchronous write timer tick pin; reads answer one clock after the offset.
`timescale 1ns/1ps
module eeprom_byte_access_ctrl #(
  parameter int RD_CYCLES = nv_access_pkg::RD_CYCLES,
  parameter int WR_TICKS  = nv_access_pkg::WR_TICKS,
  parameter int NV_DEPTH  = nv_access_pkg::NV_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] reg_bank_i,
  input  wire logic [7:0] reg_ofs_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       write_timer_tick_i,
  input  wire logic       nv_write_done_irq_enable_i,
  input  wire logic       irq_serviced_i,
  output logic            nv_write_done_flag_o,
  output logic            nv_write_irq_o
);

  localparam logic [15:0] RD_LAST = 16'(RD_CYCLES - 1);
  localparam logic [15:0] WR_LAST = 16'(WR_TICKS - 1);

  logic [7:0]              store [NV_DEPTH];
  logic [nv_access_pkg::ADDR_W-1:0] addr_ff;
  logic [7:0]              data_ff;
  nv_access_pkg::nv_ctrl_s ctrl_ff;
  nv_access_pkg::nv_state_e state_ff;
  logic [15:0]             cnt_ff;
  logic [2:0]              tick_sync_ff;
  logic                    tick_lvl_ff;
  logic [7:0]              rdata_ff;
  logic                    done_ff;
  logic                    irq_ff;

  nv_access_pkg::reg_sel_e sel;
  logic                    wr_ctrl;
  logic                    start_rd;
  logic                    start_wr;
  logic                    tick_rise;
  logic                    end_rd;
  logic                    end_wr;
  logic                    commit_wr;

  assign sel       = nv_access_pkg::reg_sel(reg_bank_i, reg_ofs_i);
  assign wr_ctrl   = reg_wr_i && sel == nv_access_pkg::SEL_CTRL;
  // Trigger only counts if its permit was already set before this write
  assign start_rd  = wr_ctrl && state_ff == nv_access_pkg::ST_IDLE && ctrl_ff.read_permit
                     && reg_wdata_i[nv_access_pkg::RD_TRIG_BIT];
  assign start_wr  = wr_ctrl && state_ff == nv_access_pkg::ST_IDLE && ctrl_ff.write_permit
                     && reg_wdata_i[nv_access_pkg::WR_TRIG_BIT] && !start_rd;
  assign tick_rise = tick_sync_ff[1] == tick_sync_ff[2] && tick_sync_ff[2] && !tick_lvl_ff;
  assign end_rd    = state_ff == nv_access_pkg::ST_READ && cnt_ff == RD_LAST;
  assign end_wr    = state_ff == nv_access_pkg::ST_WRITE && tick_rise && cnt_ff == WR_LAST;
  assign commit_wr = end_wr && ctrl_ff.write_permit;

  // Timer tick synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_sync_ff <= 3'h0;
      tick_lvl_ff  <= 1'b0;
    end else begin
      tick_sync_ff <= {tick_sync_ff[1:0], write_timer_tick_i};
      if (tick_sync_ff[1] == tick_sync_ff[2])
        tick_lvl_ff <= tick_sync_ff[2];
    end
  end

  // Cycle sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= nv_access_pkg::ST_IDLE;
      cnt_ff   <= 16'h0000;
    end else begin
      unique case (state_ff)
        nv_access_pkg::ST_IDLE: begin
          cnt_ff <= 16'h0000;
          if (start_rd)
            state_ff <= nv_access_pkg::ST_READ;
          else if (start_wr)
            state_ff <= nv_access_pkg::ST_WRITE;
        end
        nv_access_pkg::ST_READ: begin
          cnt_ff <= cnt_ff + 16'h0001;
          if (end_rd)
            state_ff <= nv_access_pkg::ST_IDLE;
        end
        nv_access_pkg::ST_WRITE: begin
          if (tick_rise)
            cnt_ff <= cnt_ff + 16'h0001;
          if (end_wr)
            state_ff <= nv_access_pkg::ST_IDLE;
        end
        default: state_ff <= nv_access_pkg::ST_IDLE;
      endcase
    end
  end

  // Control register; triggers are held by hardware while busy
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= nv_access_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.write_permit <= reg_wdata_i[nv_access_pkg::WR_PERMIT_BIT];
        ctrl_ff.read_permit  <= reg_wdata_i[nv_access_pkg::RD_PERMIT_BIT];
      end
      if (start_rd)
        ctrl_ff.read_trigger <= 1'b1;
      else if (end_rd)
        ctrl_ff.read_trigger <= 1'b0;
      if (start_wr)
        ctrl_ff.write_trigger <= 1'b1;
      else if (end_wr)
        ctrl_ff.write_trigger <= 1'b0;
    end
  end

  // Address register keeps no reset value
  always_ff @(posedge clk_i) begin
    if (reg_wr_i && sel == nv_access_pkg::SEL_ADDR)
      addr_ff <= reg_wdata_i[nv_access_pkg::ADDR_W-1:0];
  end

  // Data register; a finished read loads the fetched byte if read permit is still set
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      data_ff <= nv_access_pkg::DATA_RESET;
    else if (end_rd && ctrl_ff.read_permit)
      data_ff <= store[addr_ff];
    else if (reg_wr_i && sel == nv_access_pkg::SEL_DATA)
      data_ff <= reg_wdata_i;
  end

  // Byte store, written only at the end of a permitted write cycle
  always_ff @(posedge clk_i) begin
    if (commit_wr)
      store[addr_ff] <= data_ff;
  end

  // Read-back path, unmapped offsets answer zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (sel)
        nv_access_pkg::SEL_ADDR: rdata_ff <= {2'h0, addr_ff};
        nv_access_pkg::SEL_DATA: rdata_ff <= data_ff;
        nv_access_pkg::SEL_CTRL: rdata_ff <= {4'h0, ctrl_ff};
        nv_access_pkg::SEL_NONE: rdata_ff <= 8'h00;
      endcase
    end
  end

  // Write-done flag: setting wins over service
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end else begin
      if (end_wr)
        done_ff <= 1'b1;
      else if (irq_serviced_i)
        done_ff <= 1'b0;
      irq_ff <= (done_ff || end_wr) && nv_write_done_irq_enable_i && !(irq_serviced_i && !end_wr);
    end
  end

  assign reg_rdata_o          = rdata_ff;
  assign nv_write_done_flag_o = done_ff;
  assign nv_write_irq_o       = irq_ff;

  AST_RD_NEEDS_PERMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ctrl && !ctrl_ff.read_permit && !ctrl_ff.read_trigger |=> !ctrl_ff.read_trigger)
    else $error("read trigger set without permit");
  AST_WR_NEEDS_PERMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ctrl && !ctrl_ff.write_permit && !ctrl_ff.write_trigger |=> !ctrl_ff.write_trigger)
    else $error("write trigger set without permit");
  AST_RD_LENGTH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ctrl_ff.read_trigger) |-> ctrl_ff.read_trigger [*4] ##1 !ctrl_ff.read_trigger)
    else $error("read cycle length wrong");
  AST_RD_BUSY_TRIG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_ff == nv_access_pkg::ST_READ |-> ctrl_ff.read_trigger)
    else $error("read trigger low while reading");
  AST_RD_DATA: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    end_rd && ctrl_ff.read_permit |=> data_ff == $past(store[addr_ff]))
    else $error("fetched byte not in data register");
  AST_DATA_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !end_rd && !(reg_wr_i && sel == nv_access_pkg::SEL_DATA) |=> $stable(data_ff))
    else $error("data register changed without access");
  AST_ADDR_UPPER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(sel) == nv_access_pkg::SEL_ADDR |-> reg_rdata_o[7:6] == 2'h0)
    else $error("address upper bits not zero");
  AST_CTRL_UPPER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(sel) == nv_access_pkg::SEL_CTRL |-> reg_rdata_o[7:4] == 4'h0)
    else $error("control upper bits not zero");
  AST_WR_BLOCKED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    end_wr && !ctrl_ff.write_permit |=> store[$past(addr_ff)] == $past(store[addr_ff]))
    else $error("store written without permit");
  AST_DONE_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(ctrl_ff.write_trigger) |-> nv_write_done_flag_o)
    else $error("done flag missing after write");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_ff && nv_write_done_irq_enable_i && !irq_serviced_i |=> nv_write_irq_o)
    else $error("interrupt not raised");

  COV_READ: cover property (@(posedge clk_i) disable iff (!rst_n_i) end_rd);
  COV_WRITE: cover property (@(posedge clk_i) disable iff (!rst_n_i) commit_wr);
  COV_BLOCKED: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_ctrl && reg_wdata_i[nv_access_pkg::WR_TRIG_BIT] && !ctrl_ff.write_permit);
  COV_SET_CLEAR: cover property (@(posedge clk_i) disable iff (!rst_n_i) end_wr && irq_serviced_i);

endmodule // eeprom_byte_access_ctrl

// [verif/nv_write_timer.sv]
// Model of the free-running write timer that paces store writes.
// Assumes only its own period, which has no relation to the system clock.
`timescale 1ns/1ps
module nv_write_timer #(
  parameter real HALF_NS = 45.3
) (
  output logic tick_o
);
  // Free-running tick whose phase drifts against the system clock
  initial begin
    tick_o = 1'b0;
    forever #(HALF_NS) tick_o = ~tick_o;
  end
endmodule // nv_write_timer

// [verif/eeprom_byte_access_ctrl_test.sv]
// Self-checking bench for the nonvolatile byte access block.
// Assumes the register port timing of the block and the free-running timer model.
`timescale 1ns/1ps
module eeprom_byte_access_ctrl_test;
  localparam logic [7:0] CTRL = nv_access_pkg::CTRL_REG_OFS;
  localparam logic [7:0] ADDR = nv_access_pkg::ADDR_REG_OFS;
  localparam logic [7:0] DATA = nv_access_pkg::DATA_REG_OFS;
  localparam logic [1:0] B1   = nv_access_pkg::CTRL_BANK;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [1:0] bank    = 2'h0;
  logic [7:0] ofs     = 8'h00;
  logic       wr      = 1'b0;
  logic [7:0] wdata   = 8'h00;
  logic       ien     = 1'b0;
  logic       svc     = 1'b0;
  logic       rd_v    = 1'b0;
  logic       rd_seen = 1'b0;
  logic       tick;
  logic       flag;
  logic       irq;
  logic [7:0] rdata;
  logic [5:0] a;
  logic [7:0] d;
  logic [7:0] expq [$];
  int         n_fail  = 0;
  int         checks  = 0;
  int         cyc     = 0;

  nv_write_timer timer (.tick_o(tick));
  eeprom_byte_access_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_bank_i(bank), .reg_ofs_i(ofs),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .write_timer_tick_i(tick),
    .nv_write_done_irq_enable_i(ien), .irq_serviced_i(svc), .nv_write_done_flag_o(flag),
    .nv_write_irq_o(irq));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic put(input logic [1:0] b, input logic [7:0] o, input logic [7:0] v);
    @(posedge clk_i);
    bank  <= b;
    ofs   <= o;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  // Read whose expectation is queued for the output watcher
  task automatic rd(input logic [1:0] b, input logic [7:0] o, input logic [7:0] e);
    @(posedge clk_i);
    bank <= b;
    ofs  <= o;
    rd_v <= 1'b1;
    expq.push_back(e);
    @(posedge clk_i);
    rd_v <= 1'b0;
  endtask

  task automatic get(input logic [1:0] b, input logic [7:0] o, output logic [7:0] v);
    @(posedge clk_i);
    bank <= b;
    ofs  <= o;
    @(posedge clk_i);
    @(negedge clk_i);
    v = rdata;
  endtask

  task automatic poll(input int bitn);
    logic [7:0] v;
    int         n;
    v = 8'hff;
    n = 0;
    while (v[bitn] !== 1'b0 && n < 300) begin
      get(B1, CTRL, v);
      n++;
    end
    if (n >= 300) chk("trigger clear", 8'h00, v);
  endtask

  // Read data lands one cycle after the offset; compared once settled
  always @(negedge clk_i) begin
    if (rd_seen) chk("register read", expq.pop_front(), rdata);
    rd_seen = rd_v;
  end

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(38756));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(B1, CTRL, 8'h00);
    rd(2'h0, DATA, 8'h00);
    rd(2'h0, CTRL, 8'h00);
    put(2'h0, ADDR, 8'hff);
    rd(2'h0, ADDR, 8'h3f);
    put(B1, CTRL, 8'hf4);
    rd(B1, CTRL, 8'h00);
    put(B1, CTRL, 8'h01);
    rd(B1, CTRL, 8'h00);
    $display("reset and refusal test done");
    for (int i = 0; i < 4; i++) begin
      a = 6'($urandom);
      d = 8'($urandom);
      ien <= i[0];
      put(B1, CTRL, 8'h08);
      put(2'h0, ADDR, {2'h0, a});
      put(2'h0, DATA, d);
      put(B1, CTRL, 8'h0c);
      rd(B1, CTRL, 8'h0c);
      poll(2);
      @(negedge clk_i);
      chk("done flag", 8'h01, {7'h0, flag});
      chk("done irq", {7'h0, i[0]}, {7'h0, irq});
      @(posedge clk_i);
      svc <= 1'b1;
      @(posedge clk_i);
      svc <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      chk("flag after service", 8'h00, {7'h0, flag});
      chk("irq after service", 8'h00, {7'h0, irq});
      put(2'h0, DATA, ~d);
      put(B1, CTRL, 8'h02);
      put(2'h0, ADDR, {2'h0, a});
      put(B1, CTRL, 8'h03);
      rd(B1, CTRL, 8'h03);
      poll(0);
      rd(2'h0, DATA, d);
      rd(2'h0, DATA, d);
      $display("write and read back test %0d done", i);
    end
    put(B1, CTRL, 8'h00);
    put(2'h0, DATA, ~d);
    put(B1, CTRL, 8'h04);
    rd(B1, CTRL, 8'h00);
    put(B1, CTRL, 8'h01);
    rd(B1, CTRL, 8'h00);
    rd(2'h0, DATA, ~d);
    put(B1, CTRL, 8'h02);
    put(B1, CTRL, 8'h03);
    poll(0);
    rd(2'h0, DATA, d);
    // Write permit dropped while the cycle runs: cycle ends, store keeps old byte
    put(B1, CTRL, 8'h08);
    put(2'h0, DATA, ~d);
    put(B1, CTRL, 8'h0c);
    put(B1, CTRL, 8'h00);
    rd(B1, CTRL, 8'h04);
    poll(2);
    put(B1, CTRL, 8'h02);
    put(B1, CTRL, 8'h03);
    poll(0);
    rd(2'h0, DATA, d);
    $display("blocked access test done");
    repeat (3) @(posedge clk_i);
    end_sim();
  end
endmodule // eeprom_byte_access_ctrl_test
